//--- rx_gain_loop_detect_config.sv
// Signal-detect and clip-detect logic of the second receive gain loop.
// Assumes squared samples arrive synchronous to clk_i with a valid flag,
// and software drives a plain one-cycle register port.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Sample window: opens on first hit, fires when enough hits land inside it.
module sample_window (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Control
  input wire logic enable_i,
  input wire logic valid_i,
  input wire logic hit_i,
  input wire logic [15:0] length_i,
  input wire logic [15:0] need_i,
  // Result
  output logic fire_o,
  output logic open_o
);

  rx_gain_pkg::win_state_t state;
  logic [15:0] elapsed;
  logic [15:0] hits;
  logic [16:0] next_hits;
  logic reach;
  logic expire;

  assign next_hits = {1'b0, hits} + {16'h0000, hit_i};
  assign reach = (state == rx_gain_pkg::WIN_OPEN) ? (next_hits >= {1'b0, need_i})
                                                  : (need_i <= 16'h0001);
  // Length zero behaves as a one-sample window
  assign expire = ({1'b0, elapsed} + 17'h00001) >= {1'b0, length_i};

  always_ff @(posedge clk_i) begin
    if (srst_i || !enable_i) begin
      state <= rx_gain_pkg::WIN_IDLE;
      elapsed <= 16'h0000;
      hits <= 16'h0000;
    end else if (valid_i) begin
      case (state)
        rx_gain_pkg::WIN_IDLE: begin
          if (hit_i && !reach && length_i > 16'h0001) begin
            state <= rx_gain_pkg::WIN_OPEN;
            elapsed <= 16'h0001;
            hits <= 16'h0001;
          end
        end
        rx_gain_pkg::WIN_OPEN: begin
          if (reach || expire) begin
            state <= rx_gain_pkg::WIN_IDLE;
          end else begin
            elapsed <= 16'(elapsed + 16'h0001);
            hits <= next_hits[15:0];
          end
        end
        default: begin
          state <= rx_gain_pkg::WIN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fire_o <= 1'b0;
    end else begin
      fire_o <= enable_i && valid_i && hit_i && reach;
    end
  end

  assign open_o = (state == rx_gain_pkg::WIN_OPEN);

  sequence s_first_hit;
    enable_i && valid_i && hit_i && state == rx_gain_pkg::WIN_IDLE;
  endsequence

  sequence s_run_out;
    enable_i && valid_i && state == rx_gain_pkg::WIN_OPEN && expire && !reach;
  endsequence

  win_open_a: assert property (@(posedge clk_i) disable iff (srst_i)
    s_first_hit ##0 (need_i > 16'h0001 && length_i > 16'h0001)
    |=> (state == rx_gain_pkg::WIN_OPEN && elapsed == 16'h0001 && !fire_o))
    else $error("window did not open on first hit");

  win_fire_a: assert property (@(posedge clk_i) disable iff (srst_i)
    enable_i && valid_i && hit_i && state == rx_gain_pkg::WIN_OPEN
    && next_hits >= {1'b0, need_i}
    |=> fire_o && state == rx_gain_pkg::WIN_IDLE)
    else $error("count reached but no fire");

  win_restart_a: assert property (@(posedge clk_i) disable iff (srst_i)
    s_run_out |=> state == rx_gain_pkg::WIN_IDLE && !fire_o)
    else $error("expired window did not restart");

endmodule : sample_window

////////////////////////////////////////////////////////////////////////////
// Function
// - Floor level compared against squared bits 24 down to 8.
// - Squared sample below the floor counts as a no-signal sample.
// - First no-signal sample opens a window of loss window length samples.
// - Loss of signal declared when below-floor count reaches loss sample count.
// - Samples above the upper clip level count toward asserting clip.
// - Samples below the lower clip level count toward clearing clip.
// - Clip assertion window length in samples is programmable.
// - Clip release window length in samples is programmable.
// - Clip asserts when upper hits within assertion window reach assert count.
// - Clip clears when lower hits within release window reach release count.
// - While clipped, clip error value is added into the loop accumulator.
module rx_gain_loop_detect_config #(
  parameter int unsigned SQ_W = rx_gain_pkg::SQ_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [rx_gain_pkg::ADDR_W-1:0] addr_i,
  input wire logic [rx_gain_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [rx_gain_pkg::DATA_W-1:0] rd_data_o,
  // Sample path
  input wire rx_gain_pkg::sample_t sample_i,
  output logic out_valid_o,
  output logic [15:0] loop_error_o,
  // Detector state
  output logic loss_of_signal_o,
  output logic clip_o
);

  if (SQ_W != 32) begin : g_bad_width
    $error("squarer width must be 32");
  end

  rx_gain_pkg::cfg_t cfg;
  logic loss;
  logic clip;
  logic below_floor;
  logic above_upper;
  logic below_lower;
  logic loss_fire;
  logic assert_fire;
  logic release_fire;

  // Upper squared bits beyond 24 mean the sample is above any setting
  function automatic logic is_below(input logic [31:0] sq, input logic [15:0] lvl);
    logic over;
    over = |sq[31:rx_gain_pkg::SQ_MSB+1];
    return !over && (sq[rx_gain_pkg::SQ_MSB:rx_gain_pkg::SQ_LSB] < {1'b0, lvl});
  endfunction : is_below

  function automatic logic is_above(input logic [31:0] sq, input logic [15:0] lvl);
    logic over;
    over = |sq[31:rx_gain_pkg::SQ_MSB+1];
    return over || (sq[rx_gain_pkg::SQ_MSB:rx_gain_pkg::SQ_LSB] > {1'b0, lvl});
  endfunction : is_above

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg <= '0;
    end else if (wr_i) begin
      case (addr_i)
        rx_gain_pkg::FLOOR_OFS: cfg.signal_floor_level <= wr_data_i;
        rx_gain_pkg::LOSS_WIN_OFS: cfg.loss_window_length <= wr_data_i;
        rx_gain_pkg::LOSS_CNT_OFS: cfg.loss_sample_count <= wr_data_i;
        rx_gain_pkg::CLIP_UP_OFS: cfg.clip_upper_level <= wr_data_i;
        rx_gain_pkg::CLIP_LO_OFS: cfg.clip_lower_level <= wr_data_i;
        rx_gain_pkg::CLIP_AWIN_OFS: cfg.clip_assert_window <= wr_data_i;
        rx_gain_pkg::CLIP_RWIN_OFS: cfg.clip_release_window <= wr_data_i;
        rx_gain_pkg::CLIP_CNT_OFS: begin
          cfg.clip_assert_count <= wr_data_i[rx_gain_pkg::ASSERT_CNT_LSB +: 8];
          cfg.clip_release_count <= wr_data_i[rx_gain_pkg::RELEASE_CNT_LSB +: 8];
        end
        rx_gain_pkg::CLIP_ERR_OFS: cfg.clip_error_value <= wr_data_i;
        default: begin
        end
      endcase
    end
  end

  // Register reads, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_o <= rx_gain_pkg::REG_RST;
    end else if (rd_i) begin
      case (addr_i)
        rx_gain_pkg::FLOOR_OFS: rd_data_o <= cfg.signal_floor_level;
        rx_gain_pkg::LOSS_WIN_OFS: rd_data_o <= cfg.loss_window_length;
        rx_gain_pkg::LOSS_CNT_OFS: rd_data_o <= cfg.loss_sample_count;
        rx_gain_pkg::CLIP_UP_OFS: rd_data_o <= cfg.clip_upper_level;
        rx_gain_pkg::CLIP_LO_OFS: rd_data_o <= cfg.clip_lower_level;
        rx_gain_pkg::CLIP_AWIN_OFS: rd_data_o <= cfg.clip_assert_window;
        rx_gain_pkg::CLIP_RWIN_OFS: rd_data_o <= cfg.clip_release_window;
        rx_gain_pkg::CLIP_CNT_OFS: rd_data_o <= {cfg.clip_assert_count, cfg.clip_release_count};
        rx_gain_pkg::CLIP_ERR_OFS: rd_data_o <= cfg.clip_error_value;
        rx_gain_pkg::STATUS_OFS: rd_data_o <= {14'h0000, clip, loss};
        default: rd_data_o <= 16'h0000;
      endcase
    end else begin
      rd_data_o <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample classification
  assign below_floor = is_below(sample_i.square, cfg.signal_floor_level);
  assign above_upper = is_above(sample_i.square, cfg.clip_upper_level);
  assign below_lower = is_below(sample_i.square, cfg.clip_lower_level);

  // Loss window runs only while signal is present
  sample_window u_loss_window (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .enable_i(!loss),
    .valid_i(sample_i.valid),
    .hit_i(below_floor),
    .length_i(cfg.loss_window_length),
    .need_i(cfg.loss_sample_count),
    .fire_o(loss_fire),
    .open_o()
  );

  sample_window u_assert_window (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .enable_i(!clip),
    .valid_i(sample_i.valid),
    .hit_i(above_upper),
    .length_i(cfg.clip_assert_window),
    .need_i({8'h00, cfg.clip_assert_count}),
    .fire_o(assert_fire),
    .open_o()
  );

  sample_window u_release_window (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .enable_i(clip),
    .valid_i(sample_i.valid),
    .hit_i(below_lower),
    .length_i(cfg.clip_release_window),
    .need_i({8'h00, cfg.clip_release_count}),
    .fire_o(release_fire),
    .open_o()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Loss of signal: set by the window, cleared by a sample at or above floor
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      loss <= 1'b0;
    end else if (loss_fire) begin
      loss <= 1'b1;
    end else if (sample_i.valid && !below_floor) begin
      loss <= 1'b0;
    end
  end

  // Only one clip window is live at a time, so set and clear never collide.
  // With a count of one and back-to-back samples the assert window may fire
  // once more after the flag is already set; that second fire is harmless.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clip <= 1'b0;
    end else if (assert_fire) begin
      clip <= 1'b1;
    end else if (release_fire) begin
      clip <= 1'b0;
    end
  end

  // Loop accumulator input with clip error injected
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_valid_o <= 1'b0;
      loop_error_o <= 16'h0000;
    end else begin
      out_valid_o <= sample_i.valid;
      if (sample_i.valid) begin
        loop_error_o <= 16'(sample_i.loop_error + (clip ? cfg.clip_error_value : 16'h0000));
      end
    end
  end

  assign loss_of_signal_o = loss;
  assign clip_o = clip;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_clip_set;
    assert_fire ##1 clip;
  endsequence

  clip_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
    assert_fire && !clip |=> clip)
    else $error("clip did not set");

  clip_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
    release_fire |=> !clip)
    else $error("clip did not clear");

  clip_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    s_clip_set ##0 !release_fire |=> clip)
    else $error("clip dropped without release");

  error_add_a: assert property (@(posedge clk_i) disable iff (srst_i)
    sample_i.valid |=> out_valid_o
    && loop_error_o == 16'($past(sample_i.loop_error)
    + ($past(clip) ? $past(cfg.clip_error_value) : 16'h0000)))
    else $error("clip error not injected");

  floor_cmp_a: assert property (@(posedge clk_i) disable iff (srst_i)
    sample_i.valid && loss && !loss_fire
    && sample_i.square[31:8] >= {8'h00, cfg.signal_floor_level}
    |=> !loss)
    else $error("loss kept despite signal above floor");

  loss_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
    loss_fire |=> loss ##1 (loss || $past(sample_i.valid)))
    else $error("loss not declared");

endmodule : rx_gain_loop_detect_config

//--- rx_gain_pkg.sv
// Constants, register map and carrier types of the receive gain loop detector.
// Assumes one clock domain and a 16-bit plain register port.
package rx_gain_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SQ_W = 32;
  localparam int unsigned SQ_MSB = 24;
  localparam int unsigned SQ_LSB = 8;
  localparam int unsigned CNT_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [3:0] FLOOR_OFS = 4'h2;
  localparam logic [3:0] LOSS_WIN_OFS = 4'h3;
  localparam logic [3:0] LOSS_CNT_OFS = 4'h4;
  localparam logic [3:0] CLIP_UP_OFS = 4'h5;
  localparam logic [3:0] CLIP_LO_OFS = 4'h6;
  localparam logic [3:0] CLIP_AWIN_OFS = 4'h7;
  localparam logic [3:0] CLIP_RWIN_OFS = 4'h8;
  localparam logic [3:0] CLIP_CNT_OFS = 4'h9;
  localparam logic [3:0] CLIP_ERR_OFS = 4'ha;
  localparam logic [3:0] STATUS_OFS = 4'hb;

  localparam logic [15:0] REG_RST = 16'h0000;
  localparam int unsigned ASSERT_CNT_LSB = 8;
  localparam int unsigned RELEASE_CNT_LSB = 0;
  localparam int unsigned LOSS_BIT = 0;
  localparam int unsigned CLIP_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [15:0] signal_floor_level;
    logic [15:0] loss_window_length;
    logic [15:0] loss_sample_count;
    logic [15:0] clip_upper_level;
    logic [15:0] clip_lower_level;
    logic [15:0] clip_assert_window;
    logic [15:0] clip_release_window;
    logic [7:0] clip_assert_count;
    logic [7:0] clip_release_count;
    logic [15:0] clip_error_value;
  } cfg_t;

  typedef struct packed {
    logic valid;
    logic [31:0] square;
    logic [15:0] loop_error;
  } sample_t;

  typedef enum logic [1:0] {
    WIN_IDLE = 2'b01,
    WIN_OPEN = 2'b10
  } win_state_t;

endpackage : rx_gain_pkg

//--- sample_source.sv
// Upstream sample path model: squared samples with a valid flag.
// Assumes the caller steps it from the bench clock, one sample per call.
`timescale 1ns/100ps

module sample_source (
  // Clock
  input wire logic clk_i,
  // Samples
  output rx_gain_pkg::sample_t sample_o
);
  initial sample_o = '0;

  ////////////////////////////////////////////////////////////////////////////
  // Idle payload is inverted so stale data cannot pass for a sample
  task automatic send(input logic [31:0] sq, input logic [15:0] err);
    @(posedge clk_i);
    sample_o <= '{valid: 1'b1, square: sq, loop_error: err};
    @(posedge clk_i);
    sample_o <= '{valid: 1'b0, square: ~sq, loop_error: ~err};
  endtask : send
endmodule : sample_source

//--- tb_rx_gain_loop_detect_config.sv
// Self-checking bench of the gain loop signal and clip detector.
// Assumes the sample model drives sample_i and the bench owns the register port.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

module tb_rx_gain_loop_detect_config;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wr_data_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rd_data_o;
  rx_gain_pkg::sample_t sample_i;
  logic out_valid_o;
  logic [15:0] loop_error_o;
  logic loss_of_signal_o;
  logic clip_o;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  typedef struct {logic [3:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  row_t rows[11];
  // Levels land on squared bits 24..8
  localparam logic [31:0] B = 32'h0000ff00, E = 32'h00010000, BIG = 32'h01000000;
  localparam logic [31:0] H = 32'h00030000, M = 32'h00010000, L = 32'h00004000;

  always #4 clk_i = ~clk_i;

  sample_source src_u (.clk_i(clk_i), .sample_o(sample_i));

  rx_gain_loop_detect_config dut_u (
    .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .sample_i(sample_i),
    .out_valid_o(out_valid_o), .loop_error_o(loop_error_o),
    .loss_of_signal_o(loss_of_signal_o), .clip_o(clip_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK("rd_data_o", e, rd_data_o)
  endtask : rd_chk

  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic final_report();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // Ceiling well above the roughly 185 cycles the sequence needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 9; i++) begin
      rows[i] = '{4'(i + 2), {4'(i + 2), 12'ha5c}, {4'(i + 2), 12'ha5c}};
    end
    rows[9] = '{4'hb, 16'hffff, 16'h0000};
    rows[10] = '{4'hc, 16'h1234, 16'h0000};
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    foreach (rows[i]) rd_chk(rows[i].a, rx_gain_pkg::REG_RST);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    // Signal detect: window of 3, need 3 below-floor samples
    wr(rx_gain_pkg::FLOOR_OFS, 16'h0100);
    wr(rx_gain_pkg::LOSS_WIN_OFS, 16'h0003);
    wr(rx_gain_pkg::LOSS_CNT_OFS, 16'h0003);
    src_u.send(B, 16'h0); src_u.send(E, 16'h0); src_u.send(B, 16'h0); src_u.send(B, 16'h0);
    settle();
    `CHK("loss_of_signal_o", 1'b0, loss_of_signal_o)
    src_u.send(B, 16'h0); src_u.send(B, 16'h0);
    settle();
    `CHK("loss_of_signal_o", 1'b1, loss_of_signal_o)
    rd_chk(rx_gain_pkg::STATUS_OFS, 16'h0001);
    src_u.send(BIG, 16'h0);
    settle();
    `CHK("loss_of_signal_o", 1'b0, loss_of_signal_o)
    // Clip detect: assert 2 of 2, release 2 of 3
    wr(rx_gain_pkg::FLOOR_OFS, 16'h0000);
    wr(rx_gain_pkg::CLIP_UP_OFS, 16'h0200);
    wr(rx_gain_pkg::CLIP_LO_OFS, 16'h0080);
    wr(rx_gain_pkg::CLIP_AWIN_OFS, 16'h0002);
    wr(rx_gain_pkg::CLIP_RWIN_OFS, 16'h0003);
    wr(rx_gain_pkg::CLIP_CNT_OFS, 16'h0202);
    wr(rx_gain_pkg::CLIP_ERR_OFS, 16'h0010);
    // Strong sample above left the assert window open; one quiet sample closes it
    src_u.send(M, 16'h0);
    src_u.send(H, 16'h0); src_u.send(M, 16'h0); src_u.send(H, 16'h0); src_u.send(M, 16'h0);
    settle();
    `CHK("clip_o", 1'b0, clip_o)
    src_u.send(H, 16'h0); src_u.send(H, 16'h0);
    settle();
    `CHK("clip_o", 1'b1, clip_o)
    rd_chk(rx_gain_pkg::STATUS_OFS, 16'h0002);
    src_u.send(M, 16'h1000);
    #1;
    `CHK("out_valid_o", 1'b1, out_valid_o)
    settle();
    `CHK("loop_error_o", 16'h1010, loop_error_o)
    `CHK("out_valid_o", 1'b0, out_valid_o)
    src_u.send(L, 16'h0); src_u.send(M, 16'h0); src_u.send(M, 16'h0); src_u.send(L, 16'h0);
    settle();
    `CHK("clip_o", 1'b1, clip_o)
    src_u.send(L, 16'h0);
    settle();
    `CHK("clip_o", 1'b0, clip_o)
    src_u.send(M, 16'h1000);
    settle();
    `CHK("loop_error_o", 16'h1000, loop_error_o)
    // Mid-run reset clears the settings and the outputs
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    rd_chk(rx_gain_pkg::CLIP_ERR_OFS, rx_gain_pkg::REG_RST);
    `CHK("loop_error_o", 16'h0000, loop_error_o)
    // Zero count after reset: the first sample above the upper level sets clip
    src_u.send(M, 16'h0);
    settle();
    `CHK("clip_o", 1'b1, clip_o)
    final_report();
  end
endmodule : tb_rx_gain_loop_detect_config
